//--- dtc_defines.svh
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DTC_OFF_TIMER_CONTROL   8'h00
`define DTC_OFF_TIMER_MODE_REGISTER   8'h04
`define DTC_OFF_TIMER_CONTROL_B  8'h08
`define DTC_OFF_CKCFG  8'h0C
`define DTC_OFF_TL0    8'h10
`define DTC_OFF_TH0    8'h14
`define DTC_OFF_TL1    8'h18
`define DTC_OFF_TH1    8'h1C
`define DTC_OFF_RL0    8'h20
`define DTC_OFF_RH0    8'h24
`define DTC_OFF_RL1    8'h28
`define DTC_OFF_RH1    8'h2C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DTC_TIMER_CONTROL_TR0     4
`define DTC_TIMER_CONTROL_TF0     5
`define DTC_TIMER_CONTROL_TR1     6
`define DTC_TIMER_CONTROL_TF1     7
`define DTC_TIMER_MODE_REGISTER_MODE    0
`define DTC_TIMER_MODE_REGISTER_CT      2
`define DTC_TIMER_MODE_REGISTER_GATE    3
`define DTC_TIMER_MODE_REGISTER_STRIDE  4
`define DTC_TIMER_CONTROL_B_PSC    0
`define DTC_TIMER_CONTROL_B_STRIDE 3
`define DTC_TIMER_CONTROL_B_TIMER0_PWM_ENABLE 6
`define DTC_CKCFG_FAST   0
`define DTC_CKCFG_X2     1
`define DTC_CKCFG_TPS    4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DTC_RST_TIMER_CONTROL   8'h00
`define DTC_RST_TIMER_MODE_REGISTER   8'h00
`define DTC_RST_TIMER_CONTROL_B  8'h24
`define DTC_RST_CKCFG  8'h01
`define DTC_RST_BYTE   8'h00

`endif

//--- dtc_pkg.sv
package dtc_pkg;

  typedef enum logic [1:0] {
    DTC_VAR,
    DTC_AR16,
    DTC_AR8,
    DTC_SPLIT
  } dtc_mode_t;

endpackage

//--- dtc_top.sv
`timescale 1ns/1ns
`include "dtc_defines.svh"


module dtc_top (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // gate pins, high lets the timer run
  input  wire logic        timer0_gate_pin_i,
  input  wire logic        timer1_gate_pin_i,
  // count pins, two-way
  input  wire logic        timer0_count_pin_i,
  output logic             timer0_count_pin_o,
  output logic             timer0_count_pin_oe_o,
  input  wire logic        timer1_count_pin_i,
  output logic             timer1_count_pin_o,
  output logic             timer1_count_pin_oe_o,
  // status
  output logic             timer0_overflow_flag_o,
  output logic             timer1_overflow_flag_o,
  output logic             timer1_baud_tick_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // active low-byte bits are width field plus one
  function automatic logic [7:0] dtc_low_mask(input logic [2:0] psc);
    logic [8:0] ones;
    ones = (9'h002 << psc) - 9'h001;
    return ones[7:0];
  endfunction

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  wire        rst_n = rst_sync_q[1];

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire       setup_ph = psel_i & ~penable_i;
  wire       access   = psel_i & penable_i;
  wire       wr_en    = access & pwrite_i;
  wire [7:0] wbyte    = pwdata_i[7:0];
  wire       hit      = (paddr_i[1:0] == 2'h0) && (paddr_i <= `DTC_OFF_RH1);
  wire       wr_timer_control  = wr_en && (paddr_i == `DTC_OFF_TIMER_CONTROL);
  wire       wr_timer_mode_register  = wr_en && (paddr_i == `DTC_OFF_TIMER_MODE_REGISTER);
  wire       wr_timer_control_b = wr_en && (paddr_i == `DTC_OFF_TIMER_CONTROL_B);
  wire       wr_ckcfg = wr_en && (paddr_i == `DTC_OFF_CKCFG);

  assign pready_o  = 1'b1;
  assign pslverr_o = access & ~hit;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [7:0] timer_mode_register_q;
  logic [7:0] timer_control_b_q;
  logic [7:0] ckcfg_q;
  logic [1:0] run_q;
  logic [1:0] tf_q;
  logic [1:0] tf_set;

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_mode_register_q  <= `DTC_RST_TIMER_MODE_REGISTER;
      timer_control_b_q <= `DTC_RST_TIMER_CONTROL_B;
      ckcfg_q <= `DTC_RST_CKCFG;
    end
    else
    begin
      if (wr_timer_mode_register)
        timer_mode_register_q <= wbyte;
      if (wr_timer_control_b)
        timer_control_b_q <= wbyte;
      if (wr_ckcfg)
        ckcfg_q <= wbyte;
    end
  end

  // hardware set wins over a software clear in the same cycle
  wire [1:0] tf_wr = {wbyte[`DTC_TIMER_CONTROL_TF1], wbyte[`DTC_TIMER_CONTROL_TF0]};
  wire [1:0] tr_wr = {wbyte[`DTC_TIMER_CONTROL_TR1], wbyte[`DTC_TIMER_CONTROL_TR0]};

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_q <= 2'h0;
      tf_q  <= 2'h0;
    end
    else
    begin
      run_q <= wr_timer_control ? tr_wr : run_q;
      tf_q  <= (wr_timer_control ? tf_wr : tf_q) | tf_set;
    end
  end

  // ----------------------------------------------------------------
  // shared prescaler
  // ----------------------------------------------------------------
  wire [3:0] shared_timer_prescaler  = ckcfg_q[`DTC_CKCFG_TPS +: 4];
  wire       fast = ckcfg_q[`DTC_CKCFG_FAST];
  logic [3:0] ps_q;
  logic       half_q;
  wire        ps_tick = (ps_q == shared_timer_prescaler);

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ps_q   <= 4'h0;
      half_q <= 1'b0;
    end
    else
    begin
      ps_q   <= ps_tick ? 4'h0 : ps_q + 4'h1;
      half_q <= half_q ^ ps_tick;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  wire [1:0] gate_pin = {timer1_gate_pin_i, timer0_gate_pin_i};
  wire [1:0] cnt_pin  = {timer1_count_pin_i, timer0_count_pin_i};
  logic [1:0] pin_prev_q;

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      pin_prev_q <= 2'h3;
    else
      pin_prev_q <= cnt_pin;
  end

  wire [1:0] rate_en;
  wire [1:0] pin_fall;
  wire [1:0] pwm_out;
  wire [1:0] pwm_on;
  wire       split0 = (dtc_pkg::dtc_mode_t'(timer_mode_register_q[1:0]) == dtc_pkg::DTC_SPLIT);

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++)
  begin : g_tmr
    localparam int NB = i * `DTC_TIMER_MODE_REGISTER_STRIDE;
    wire dtc_pkg::dtc_mode_t mode = dtc_pkg::dtc_mode_t'(timer_mode_register_q[NB + `DTC_TIMER_MODE_REGISTER_MODE +: 2]);
    wire [2:0] psc     = timer_control_b_q[i * `DTC_TIMER_CONTROL_B_STRIDE + `DTC_TIMER_CONTROL_B_PSC +: 3];
    wire       pwm_en  = timer_control_b_q[`DTC_TIMER_CONTROL_B_TIMER0_PWM_ENABLE + i];
    wire       ctr_sel = timer_mode_register_q[NB + `DTC_TIMER_MODE_REGISTER_CT];
    wire       gate_ok = ~timer_mode_register_q[NB + `DTC_TIMER_MODE_REGISTER_GATE] | gate_pin[i];
    wire       held    = (i == 1) && (mode == dtc_pkg::DTC_SPLIT);
    wire [7:0] mask    = dtc_low_mask(psc);
    wire       pwm_act = pwm_en && (mode == dtc_pkg::DTC_VAR || mode == dtc_pkg::DTC_AR16);
    // compatibility mode always divides; double-rate there halves again
    assign rate_en[i] = fast ? (ckcfg_q[`DTC_CKCFG_X2 + i] ? ps_tick : 1'b1)
                             : (ps_tick & (~ckcfg_q[`DTC_CKCFG_X2 + i] | half_q));
    // the pin is ours while pwm drives it, so no counting from it then
    assign pin_fall[i] = pin_prev_q[i] & ~cnt_pin[i] & ~pwm_en;
    wire inc = run_q[i] & gate_ok & ~held
             & (ctr_sel ? pin_fall[i] : rate_en[i]);
    wire hi_inc = (i == 0) && split0 && run_q[1] && rate_en[0];

    logic [7:0] tl_q;
    logic [7:0] th_q;
    logic [7:0] rl_q;
    logic [7:0] rh_q;
    logic [7:0] ocr_q;
    logic       pwm_q;
    logic [7:0] tl_d;
    logic [7:0] th_d;
    logic [7:0] ocr_d;
    logic       pwm_d;
    logic       ovf;
    logic       ovf_hi;

    always_comb
    begin
      logic lo_wrap;
      lo_wrap = 1'b0;
      tl_d    = tl_q;
      th_d    = th_q;
      ocr_d   = ocr_q;
      pwm_d   = pwm_q;
      ovf     = 1'b0;
      ovf_hi  = 1'b0;
      if (hi_inc)
      begin
        th_d   = th_q + 8'h01;
        ovf_hi = (th_q == 8'hFF);
      end
      if (inc)
      begin
        case (mode)
          dtc_pkg::DTC_VAR:
          begin
            lo_wrap = ((tl_q & mask) == mask);
            tl_d    = lo_wrap ? (tl_q & ~mask) : tl_q + 8'h01;
          end
          dtc_pkg::DTC_AR16:
          begin
            lo_wrap = (tl_q == 8'hFF);
            tl_d    = (lo_wrap && pwm_en) ? rl_q : tl_q + 8'h01;
          end
          dtc_pkg::DTC_AR8:
          begin
            ovf  = (tl_q == 8'hFF);
            tl_d = ovf ? th_q : tl_q + 8'h01;
          end
          default:
          begin
            ovf  = (tl_q == 8'hFF);
            tl_d = tl_q + 8'h01;
          end
        endcase
        if (lo_wrap)
        begin
          th_d = th_q + 8'h01;
          ovf  = (th_q == 8'hFF);
          if (ovf && !pwm_en && mode == dtc_pkg::DTC_AR16)
          begin
            tl_d = rl_q;
            th_d = rh_q;
          end
          if (pwm_act)
          begin
            // duty written mid-period waits for the wrap, no glitch
            if (ovf)
            begin
              ocr_d = rh_q;
              pwm_d = (rh_q != 8'h00);
            end
            else if (th_d == ocr_q)
              pwm_d = 1'b0;
          end
        end
      end
    end

    wire [7:0] a_tl = (i == 0) ? `DTC_OFF_TL0 : `DTC_OFF_TL1;
    wire [7:0] a_th = (i == 0) ? `DTC_OFF_TH0 : `DTC_OFF_TH1;
    wire [7:0] a_rl = (i == 0) ? `DTC_OFF_RL0 : `DTC_OFF_RL1;
    wire [7:0] a_rh = (i == 0) ? `DTC_OFF_RH0 : `DTC_OFF_RH1;

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
      if (!rst_n)
      begin
        tl_q  <= `DTC_RST_BYTE;
        th_q  <= `DTC_RST_BYTE;
        rl_q  <= `DTC_RST_BYTE;
        rh_q  <= `DTC_RST_BYTE;
        ocr_q <= `DTC_RST_BYTE;
        pwm_q <= 1'b0;
      end
      else
      begin
        tl_q  <= (wr_en && paddr_i == a_tl) ? wbyte : tl_d;
        th_q  <= (wr_en && paddr_i == a_th) ? wbyte : th_d;
        rl_q  <= (wr_en && paddr_i == a_rl) ? wbyte : rl_q;
        rh_q  <= (wr_en && paddr_i == a_rh) ? wbyte : rh_q;
        ocr_q <= ocr_d;
        pwm_q <= pwm_act & pwm_d;
      end
    end

    assign pwm_out[i] = pwm_q;
    assign pwm_on[i]  = pwm_en;
  end

  // ----------------------------------------------------------------
  // flags, pins, baud tick
  // ----------------------------------------------------------------
  // timer 1 keeps counting under split but its flag belongs to timer 0 high
  assign tf_set[0] = g_tmr[0].ovf;
  assign tf_set[1] = split0 ? g_tmr[0].ovf_hi : g_tmr[1].ovf;

  logic baud_q;

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      baud_q <= 1'b0;
    else
      baud_q <= g_tmr[1].ovf;
  end

  assign timer1_baud_tick_o     = baud_q;
  assign timer0_overflow_flag_o = tf_q[0];
  assign timer1_overflow_flag_o = tf_q[1];
  assign timer0_count_pin_o     = pwm_out[0];
  assign timer0_count_pin_oe_o  = pwm_on[0];
  assign timer1_count_pin_o     = pwm_out[1];
  assign timer1_count_pin_oe_o  = pwm_on[1];

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire [7:0] timer_control_rd = {tf_q[1], run_q[1], tf_q[0], run_q[0], 4'h0};
  wire [7:0] rd_byte =
    (paddr_i == `DTC_OFF_TIMER_CONTROL)  ? timer_control_rd :
    (paddr_i == `DTC_OFF_TIMER_MODE_REGISTER)  ? timer_mode_register_q :
    (paddr_i == `DTC_OFF_TIMER_CONTROL_B) ? timer_control_b_q :
    (paddr_i == `DTC_OFF_CKCFG) ? ckcfg_q :
    (paddr_i == `DTC_OFF_TL0)   ? g_tmr[0].tl_q :
    (paddr_i == `DTC_OFF_TH0)   ? g_tmr[0].th_q :
    (paddr_i == `DTC_OFF_TL1)   ? g_tmr[1].tl_q :
    (paddr_i == `DTC_OFF_TH1)   ? g_tmr[1].th_q :
    (paddr_i == `DTC_OFF_RL0)   ? g_tmr[0].rl_q :
    (paddr_i == `DTC_OFF_RH0)   ? g_tmr[0].rh_q :
    (paddr_i == `DTC_OFF_RL1)   ? g_tmr[1].rl_q :
    (paddr_i == `DTC_OFF_RH1)   ? g_tmr[1].rh_q : 8'h00;

  // sampled in setup so the zero-wait access phase has data ready
  logic [31:0] prdata_q;

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      prdata_q <= 32'h0000_0000;
    else if (setup_ph)
      prdata_q <= {24'h00_0000, rd_byte};
  end

  assign prdata_o = prdata_q;

endmodule

//--- dtc_top_assertions.sv
`timescale 1ns/1ns
`include "dtc_defines.svh"

module dtc_top_assertions (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // apb request
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  // watched outputs
  input  wire logic        timer0_count_pin_oe_o,
  input  wire logic        timer1_count_pin_oe_o,
  input  wire logic        timer0_overflow_flag_o,
  input  wire logic        timer1_overflow_flag_o
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire wr      = psel_i & penable_i & pwrite_i;
  wire wr_timer_control = wr & (paddr_i == `DTC_OFF_TIMER_CONTROL);
  wire wr_tcb  = wr & (paddr_i == `DTC_OFF_TIMER_CONTROL_B);
  wire clr1    = wr_timer_control & ~pwdata_i[`DTC_TIMER_CONTROL_TF1];

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  AST_PWM0_OE: assert property (wr_tcb |=> timer0_count_pin_oe_o == $past(pwdata_i[6]))
    else $error("pwm0 output enable does not follow control write");
  AST_PWM1_OE: assert property (wr_tcb |=> timer1_count_pin_oe_o == $past(pwdata_i[7]))
    else $error("pwm1 output enable does not follow control write");
  AST_OE0_HOLD: assert property ($changed(timer0_count_pin_oe_o) |-> $past(wr_tcb))
    else $error("pwm0 output enable changed without control write");
  AST_OE1_HOLD: assert property (!wr_tcb ##1 !wr_tcb |=> $stable(timer1_count_pin_oe_o))
    else $error("pwm1 output enable changed without control write");
  AST_FLAG0_SWSET: assert property (wr_timer_control && pwdata_i[5] |=> timer0_overflow_flag_o)
    else $error("flag0 not set by software write");
  AST_FLAG1_SWSET: assert property (wr_timer_control && pwdata_i[7] |=> timer1_overflow_flag_o)
    else $error("flag1 not set by software write");
  AST_FLAG0_STICKY: assert property (timer0_overflow_flag_o && !wr_timer_control |=> timer0_overflow_flag_o)
    else $error("flag0 dropped without software clear");
  AST_FLAG1_FALL: assert property ($fell(timer1_overflow_flag_o) |-> $past(clr1))
    else $error("flag1 fell without software clear");

  COV_PWM0_ON: cover property (wr_tcb && pwdata_i[6]);
  COV_FLAG0: cover property ($rose(timer0_overflow_flag_o) && !$past(wr_timer_control));
  COV_FLAG1: cover property ($rose(timer1_overflow_flag_o) && !$past(wr_timer_control));
endmodule

bind dtc_top dtc_top_assertions dtc_top_assertions_i (
  .core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .timer0_count_pin_oe_o(timer0_count_pin_oe_o),
  .timer1_count_pin_oe_o(timer1_count_pin_oe_o),
  .timer0_overflow_flag_o(timer0_overflow_flag_o),
  .timer1_overflow_flag_o(timer1_overflow_flag_o)
);

//--- testbench.sv
`timescale 1ns/1ns
`include "dtc_defines.svh"

module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic        timer0_gate_enable = 1'b0;
  logic        timer1_gate_enable = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        serr;
  logic        pin0;
  logic        oe0;
  logic        baud;
  logic        pin1;
  logic        oe1;
  logic        flag0;
  logic        flag1;
  logic        cnt0 = 1'b1;
  logic        cnt1 = 1'b1;
  logic [7:0]  ck;
  logic [7:0]  rdat;
  logic [7:0]  th;
  logic [7:0]  tl;
  logic [7:0]  mk;
  logic [7:0]  o;
  logic [15:0] seed = 16'h0008;
  logic [15:0] r;
  logic [15:0] rld;
  logic [16:0] s;
  logic [2:0]  nib;
  logic [1:0]  m;
  logic [2:0]  p;
  logic        t;
  int          n;
  int          hi;
  int          tk;
  int          hi1;
  int          cycles = 0;
  int          error_cnt = 0;
  int          tests_run = 0;

  always #25 clk = ~clk;

  dtc_top dtc_top_i (
    .core_clk_i(clk),
    .reset_n_i(rst_n),
    .psel_i(psel),
    .penable_i(penable),
    .pwrite_i(pwrite),
    .paddr_i(paddr),
    .pwdata_i(pwdata),
    .prdata_o(prdata),
    .pready_o(pready),
    .pslverr_o(serr),
    .timer0_gate_pin_i(timer0_gate_enable),
    .timer1_gate_pin_i(timer1_gate_enable),
    .timer0_count_pin_i(cnt0),
    .timer0_count_pin_o(pin0),
    .timer0_count_pin_oe_o(oe0),
    .timer1_count_pin_i(cnt1),
    .timer1_count_pin_o(pin1),
    .timer1_count_pin_oe_o(oe1),
    .timer0_overflow_flag_o(flag0),
    .timer1_overflow_flag_o(flag1),
    .timer1_baud_tick_o(baud)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_n(input string nm, input int e, input int g);
    tests_run++;
    if (g != e)
    begin
      error_cnt++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // request stays up until next call or idle, so transfers run back to back
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rdat = prdata[7:0];
  endtask

  task automatic idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // baud pulses in 512 clocks, timer 1 reloading every 4 ticks
  function automatic int exp_ticks(input logic [7:0] c);
    int per;
    per = c[0] ? (c[2] ? int'(c[7:4]) + 1 : 1) : (int'(c[7:4]) + 1) * (c[2] ? 2 : 1);
    return 512 / (4 * per);
  endfunction

  // one count tick; returns {overflow, high, low}
  function automatic logic [16:0] step(input logic [1:0] md, input logic [2:0] pw,
                                       input logic [7:0] h, input logic [7:0] l,
                                       input logic [15:0] rl);
    logic [7:0] k;
    logic       c;
    logic       ov;
    k = 8'hFF >> (3'd7 - pw);
    c = ((l & k) == k);
    case (md)
      2'd0: ov = c && (h == 8'hFF);
      2'd1: ov = ({h, l} == 16'hFFFF);
      default: ov = (l == 8'hFF);
    endcase
    if (md == 2'd0)
      {h, l} = c ? {h + 8'h01, l & ~k} : {h, l + 8'h01};
    else if (md == 2'd1)
      {h, l} = ov ? rl : {h, l} + 16'h0001;
    else
      l = (ov && md == 2'd2) ? h : l + 8'h01;
    return {ov, h, l};
  endfunction

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      tally_and_finish;
    end
  end

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 12; i++)
    begin
      apb(1'b0, 8'(4 * i), 8'h00);
      chk("reset value", i == 2 ? 8'h24 : (i == 3 ? 8'h01 : 8'h00), rdat);
    end
    apb(1'b0, 8'h30, 8'h00);
    chk("unmapped error", 8'h01, {7'h00, serr});
    apb(1'b1, `DTC_OFF_TIMER_CONTROL, 8'hA0);
    apb(1'b0, `DTC_OFF_TIMER_CONTROL, 8'h00);
    chk("flags set", 8'hA0, rdat);
    for (int i = 0; i < 40; i++)
    begin
      seed = lfsr(seed);
      r = seed;
      seed = lfsr(seed);
      rld = seed;
      {t, m, p} = {r[8], r[1:0], r[4:2]};
      nib = {r[5], r[15:13] == 3'd0, 1'b0};
      th = 8'hFF ^ {6'h00, r[11:10]};
      tl = 8'hFF ^ {5'h00, r[14:12]};
      o = t ? 8'h08 : 8'h00;
      n = (nib[1] || (t && m == 2'd3) || (r[5] && !r[6])) ? 0 : 2;
      timer0_gate_enable <= r[6];
      timer1_gate_enable <= r[6];
      apb(1'b1, `DTC_OFF_TIMER_MODE_REGISTER, t ? {nib[2:1], m, 4'h0} : {4'h0, nib[2:1], m});
      apb(1'b1, `DTC_OFF_TIMER_CONTROL_B, t ? {2'b00, p, 3'b000} : {5'b00000, p});
      apb(1'b1, `DTC_OFF_TL0 + o, tl);
      apb(1'b1, `DTC_OFF_TH0 + o, th);
      apb(1'b1, `DTC_OFF_RL0 + o, rld[7:0]);
      apb(1'b1, `DTC_OFF_RH0 + o, rld[15:8]);
      apb(1'b1, `DTC_OFF_TIMER_CONTROL, t ? 8'h40 : 8'h10);
      apb(1'b1, `DTC_OFF_TIMER_CONTROL, 8'h00);
      s = {1'b0, th, tl};
      for (int k = 0; k < n; k++)
        s = step(m, p, s[15:8], s[7:0], rld);
      mk = (m == 2'd0) ? (8'hFF >> (3'd7 - p)) : 8'hFF;
      apb(1'b0, `DTC_OFF_TL0 + o, 8'h00);
      chk("low byte", s[7:0] & mk, rdat & mk);
      apb(1'b0, `DTC_OFF_TH0 + o, 8'h00);
      chk("high byte", s[15:8], rdat);
      apb(1'b0, `DTC_OFF_TIMER_CONTROL, 8'h00);
      chk("overflow flag", {7'h00, s[16]}, {7'h00, rdat[5 + 2 * t]});
      chk("flag output", {7'h00, s[16]}, {7'h00, t ? flag1 : flag0});
      idle;
    end
    // counter mode on both timers, fall count drawn at random
    seed = lfsr(seed);
    n = int'(seed[3:0]) + 1;
    apb(1'b1, `DTC_OFF_TIMER_MODE_REGISTER, 8'h55);
    apb(1'b1, `DTC_OFF_TL0, 8'h00);
    apb(1'b1, `DTC_OFF_TH0, 8'h00);
    apb(1'b1, `DTC_OFF_TL1, 8'h00);
    apb(1'b1, `DTC_OFF_TH1, 8'h00);
    apb(1'b1, `DTC_OFF_TIMER_CONTROL, 8'h50);
    idle;
    repeat (n)
    begin
      cnt0 <= 1'b0;
      cnt1 <= 1'b0;
      @(posedge clk);
      cnt0 <= 1'b1;
      cnt1 <= 1'b1;
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    apb(1'b1, `DTC_OFF_TIMER_CONTROL, 8'h00);
    apb(1'b0, `DTC_OFF_TL0, 8'h00);
    chk("falls counted timer0", 8'(n), rdat);
    apb(1'b0, `DTC_OFF_TL1, 8'h00);
    chk("falls counted timer1", 8'(n), rdat);
    idle;
    // pwm on timer 0, timer 1 as an 8-bit reload tick source
    for (int pm = 0; pm < 2; pm++)
    begin
      apb(1'b1, `DTC_OFF_TIMER_CONTROL, 8'h00);
      apb(1'b1, `DTC_OFF_TIMER_MODE_REGISTER, 8'h20 + {6'h00, pm[1:0]});
      apb(1'b1, `DTC_OFF_TIMER_CONTROL_B, 8'hC0);
      apb(1'b1, `DTC_OFF_RL0, 8'hFE);
      // low byte near its wrap so the first period starts soon
      apb(1'b1, `DTC_OFF_TL0, 8'hFE);
      apb(1'b1, `DTC_OFF_TL1, 8'hFC);
      apb(1'b1, `DTC_OFF_TH1, 8'hFC);
      apb(1'b1, `DTC_OFF_RH0, 8'h00);
      apb(1'b1, `DTC_OFF_TIMER_CONTROL, 8'h50);
      idle;
      chk("pwm enable", 8'h01, {7'h00, oe0});
      chk("pwm1 enable", 8'h01, {7'h00, oe1});
      repeat (600) @(posedge clk);
      hi = 0;
      repeat (512) @(negedge clk) hi += (pin0 !== 1'b0);
      @(posedge clk);
      chk_n("duty zero high cycles", 0, hi);
      apb(1'b1, `DTC_OFF_RH0, 8'h40);
      idle;
      repeat (600) @(posedge clk);
      {hi, tk, hi1} = 0;
      repeat (512)
      begin
        @(negedge clk);
        hi += (pin0 !== 1'b0);
        tk += (baud !== 1'b0);
        hi1 += (pin1 !== 1'b0);
      end
      @(posedge clk);
      chk_n("pwm high cycles", 128, hi);
      chk_n("baud ticks", 128, tk);
      // timer 1 in 8-bit reload mode keeps its enabled pin low
      chk_n("pwm1 pin high cycles", 0, hi1);
    end
    // shared prescaler corners: fast and compatibility, double-rate on and off
    for (int j = 0; j < 4; j++)
    begin
      ck = (j == 0) ? 8'h13 : ((j == 1) ? 8'h15 : ((j == 2) ? 8'h10 : 8'h14));
      apb(1'b1, `DTC_OFF_CKCFG, ck);
      idle;
      repeat (64) @(posedge clk);
      tk = 0;
      repeat (512) @(negedge clk) tk += (baud !== 1'b0);
      @(posedge clk);
      chk_n("prescaled baud ticks", exp_ticks(ck), tk);
    end
    tally_and_finish;
  end
endmodule
